// *** tcc_defines.svh ***
/*
 Register offsets, field positions and reset values of the timer core
 and of its host controller. Assumes inclusion by bare name.
*/
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// ======================================
// device byte registers
`define TCC_A_CTRL   5'h0E
`define TCC_A_CNT_HI 5'h0F
`define TCC_A_CNT_LO 5'h10
`define TCC_A_PER_HI 5'h11
`define TCC_A_PER_LO 5'h12
// ======================================
// control/status fields
`define TCC_B_FLAG   7
`define TCC_B_IEN    6
`define TCC_B_HALT   5
`define TCC_B_CLR    4
`define TCC_SEL_EXT  3'h7
`define TCC_SEL_RST  3'h0
`define TCC_CNT_RST  16'h0000
`define TCC_PER_RST  16'hFFFF
// ======================================
// host AXI4-Lite map and fields
`define TCC_X_CMD    4'h0
`define TCC_X_STAT   4'h4
`define TCC_C_WE     16
`define TCC_S_BUSY   16
`define TCC_OKAY     2'h0
`define TCC_SLVERR   2'h2
`endif

// *** tcc_pkg.sv ***
/*
 Types shared by the timer core, its host controller and the link.
 Assumes tcc_defines.svh carries the numeric constants.
*/
package tcc_pkg;
   // ======================================
   // types
   typedef logic [4:0] tcc_addr_t;
   typedef logic [7:0] tcc_byte_t;
   typedef enum logic [2:0] {
      H_IDLE  = 3'b001,
      H_ISSUE = 3'b010,
      H_WAIT  = 3'b100
   } tcc_hstate_t;
endpackage

// *** tcc_if.sv ***
/*
 Byte register link between host controller and timer core.
 Assumes both ends run on the same aclk.
*/
interface tcc_if;
   import tcc_pkg::*;
   tcc_addr_t reg_addr;
   logic      reg_wr;
   logic      reg_rd;
   tcc_byte_t reg_wdata;
   tcc_byte_t reg_rdata;
   logic      reg_rvalid;
   modport device (
      input  reg_addr, reg_wr, reg_rd, reg_wdata,
      output reg_rdata, reg_rvalid
   );
   modport host (
      output reg_addr, reg_wr, reg_rd, reg_wdata,
      input  reg_rdata, reg_rvalid
   );
endinterface

// *** tcc_core.sv ***
/*
 Sixteen-bit timer core: prescaler, external clock pin, modulo period,
 wrap flag with interrupt, halt/clear and buffered counter read.
 Assumes a host on the same aclk driving one-cycle strobes on tcc_if.
*/
// How it works
// - divider select picks bus/2^n or external pin
// - reset clears divider select to undivided
// - external clock at most 4 MHz, bus/2; the edge filter needs each level held two aclk cycles
// - selected external pin is forced input
// - match period: set flag, restart at zero
// - flag clears by read-then-write-zero, guarded
// - interrupt while flag and enable set
// - halt bit holds counter; reset sets it
// - halt inhibits captures on capture channels
// - clear bit zeroes counter, prescaler; reads 0
// - halt plus clear stops at zero
// - high read latches low byte until read
// - counter bytes read-only, zero after reset
// - software reads low byte after break read
// - period high write suppresses flag until low
// - reset sets period registers all ones
// - software clears counter before period writes
// - keep halt clear when waking from wait
// - each channel pin capture or compare
`include "tcc_defines.svh"
module tcc_core #(
   parameter int PSC_W = 6
) (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       clk_en,
   // register link
   tcc_if.device           bus,
   // pins and system
   input  wire logic       external_timer_clock_pin,
   input  wire logic       port_direction_bit,
   input  wire logic       break_active,
   input  wire logic [1:0] channel_mode,
   // status out
   output logic            clock_pin_oe,
   output logic [1:0]      channel_pin_oe,
   output logic            capture_inhibit,
   output logic            wrap_irq,
   output logic            wrap_event,
   output logic [15:0]     count_value
);
   import tcc_pkg::*;

   logic [2:0]       sel_ff;
   logic             ien_ff, halt_ff, flag_ff, arm_ff;
   logic [15:0]      cnt_ff, per_ff;
   logic             per_pend_ff;
   logic [PSC_W-1:0] psc_ff;
   logic             s1_ff, s2_ff, s3_ff, lvl_ff;
   logic             latched_ff;
   tcc_byte_t        buf_ff, rdata_ff;
   logic             rvalid_ff;
   logic             wr_ctrl, rd_ctrl, rd_hi, rd_lo;
   logic             ext_rise, tick, run, wrap, set_flag, clr_req;
   tcc_byte_t        ctrl_rd;

   // ======================================
   // helpers
   // tick of the 2^sel divider: low sel bits of prescaler all ones
   function automatic logic div_tick(input logic [2:0] sel,
                                     input logic [PSC_W-1:0] psc);
      logic [PSC_W-1:0] mask;
      mask = ~({PSC_W{1'b1}} << sel);
      return (psc & mask) == mask;
   endfunction

   function automatic logic hit(input tcc_addr_t a, input tcc_addr_t r);
      return a == r;
   endfunction

   // ======================================
   // decode
   assign wr_ctrl  = bus.reg_wr & hit(bus.reg_addr, `TCC_A_CTRL);
   assign rd_ctrl  = bus.reg_rd & hit(bus.reg_addr, `TCC_A_CTRL);
   assign rd_hi    = bus.reg_rd & hit(bus.reg_addr, `TCC_A_CNT_HI);
   assign rd_lo    = bus.reg_rd & hit(bus.reg_addr, `TCC_A_CNT_LO);
   assign clr_req  = wr_ctrl & bus.reg_wdata[`TCC_B_CLR];
   // edge seen only once stage two and three agree
   assign ext_rise = (s2_ff == s3_ff) & s2_ff & ~lvl_ff;
   // external pin or prescaler tap
   assign tick     = (sel_ff == `TCC_SEL_EXT) ? ext_rise :
                     div_tick(sel_ff, psc_ff);
   // break freezes the count like halt does
   assign run      = ~halt_ff & ~break_active & tick;
   assign wrap     = cnt_ff == per_ff;
   // flag held off while period write half done
   assign set_flag = run & wrap & ~per_pend_ff;
   // clear bit never reads back set
   assign ctrl_rd  = {flag_ff, ien_ff, halt_ff, 1'b0,
                      1'b0, sel_ff};

   // ======================================
   // external clock pin resynchroniser
   // source assumed to hold each level for two aclk cycles, so no edge is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff  <= 1'b0;
         s2_ff  <= 1'b0;
         s3_ff  <= 1'b0;
         lvl_ff <= 1'b0;
      end else if (clk_en) begin
         s1_ff <= external_timer_clock_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            lvl_ff <= s2_ff;
         end
      end
   end

   // ======================================
   // control register fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_ff  <= `TCC_SEL_RST;
         ien_ff  <= 1'b0;
         halt_ff <= 1'b1;
      end else if (clk_en && wr_ctrl) begin
         sel_ff  <= bus.reg_wdata[2:0];
         ien_ff  <= bus.reg_wdata[`TCC_B_IEN];
         halt_ff <= bus.reg_wdata[`TCC_B_HALT];
      end
   end

   // ======================================
   // prescaler and counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psc_ff <= '0;
         cnt_ff <= `TCC_CNT_RST;
      end else if (clk_en) begin
         if (clr_req) begin
            psc_ff <= '0;
            cnt_ff <= `TCC_CNT_RST;
         end else begin
            psc_ff <= psc_ff + 1'b1;
            if (run) begin
               // restart at zero on the tick after the match
               cnt_ff <= wrap ? `TCC_CNT_RST :
                         cnt_ff + 16'h0001;
            end
         end
      end
   end

   // ======================================
   // period registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_ff      <= `TCC_PER_RST;
         per_pend_ff <= 1'b0;
      end else if (clk_en && bus.reg_wr) begin
         if (hit(bus.reg_addr, `TCC_A_PER_HI)) begin
            per_ff[15:8] <= bus.reg_wdata;
            per_pend_ff  <= 1'b1;
         end else if (hit(bus.reg_addr, `TCC_A_PER_LO)) begin
            per_ff[7:0]  <= bus.reg_wdata;
            per_pend_ff  <= 1'b0;
         end
      end
   end

   // ======================================
   // wrap flag with two-step clear
   // a new wrap disarms the clear, so a pending request is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ff <= 1'b0;
         arm_ff  <= 1'b0;
      end else if (clk_en) begin
         if (set_flag) begin
            flag_ff <= 1'b1;
            arm_ff  <= 1'b0;
         end else if (wr_ctrl) begin
            if (arm_ff && !bus.reg_wdata[`TCC_B_FLAG]) begin
               flag_ff <= 1'b0;
            end
            arm_ff <= 1'b0;
         end else if (rd_ctrl && flag_ff) begin
            arm_ff <= 1'b1;
         end
      end
   end

   // ======================================
   // buffered counter read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_ff <= 1'b0;
         buf_ff     <= '0;
      end else if (clk_en) begin
         if (rd_hi && !latched_ff) begin
            buf_ff     <= cnt_ff[7:0];
            latched_ff <= 1'b1;
         end else if (rd_lo) begin
            latched_ff <= 1'b0;
         end
      end
   end

   // ======================================
   // read answer one cycle after the strobe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_ff  <= '0;
         rvalid_ff <= 1'b0;
      end else if (clk_en) begin
         rvalid_ff <= bus.reg_rd;
         // data only moves on a read, so it stands until the next one
         if (bus.reg_rd) begin
            unique case (1'b1)
               rd_ctrl: rdata_ff <= ctrl_rd;
               rd_hi:   rdata_ff <= cnt_ff[15:8];
               rd_lo:   rdata_ff <= latched_ff ? buf_ff :
                                    cnt_ff[7:0];
               hit(bus.reg_addr, `TCC_A_PER_HI):
                        rdata_ff <= per_ff[15:8];
               hit(bus.reg_addr, `TCC_A_PER_LO):
                        rdata_ff <= per_ff[7:0];
               default: rdata_ff <= '0;
            endcase
         end
      end
   end
   assign bus.reg_rdata  = rdata_ff;
   assign bus.reg_rvalid = rvalid_ff;

   // ======================================
   // outputs to the system and pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_pin_oe    <= 1'b0;
         channel_pin_oe  <= '0;
         capture_inhibit <= 1'b0;
         wrap_irq        <= 1'b0;
         wrap_event      <= 1'b0;
         count_value     <= `TCC_CNT_RST;
      end else if (clk_en) begin
         // pin stays input while it clocks the counter
         clock_pin_oe    <= port_direction_bit &
                            (sel_ff != `TCC_SEL_EXT);
         channel_pin_oe  <= channel_mode;
         capture_inhibit <= halt_ff & ~&channel_mode;
         wrap_irq        <= flag_ff & ien_ff;
         wrap_event      <= set_flag;
         count_value     <= cnt_ff;
      end
   end
endmodule

// *** tcc_host.sv ***
/*
 Host controller: AXI4-Lite slave that turns command words into byte
 accesses on tcc_if. Assumes the core answers reads one cycle later.
*/
`include "tcc_defines.svh"
module tcc_host (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // write address and data
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // read
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // link and status
   tcc_if.host              bus,
   output logic             wait_allowed
);
   import tcc_pkg::*;

   tcc_hstate_t st_ff;
   logic [3:0]  awaddr_ff;
   logic [31:0] wdata_ff, cmd_ff;
   tcc_addr_t   op_addr_ff [2];
   tcc_byte_t   op_data_ff [2];
   logic        op_we_ff   [2];
   logic        idx_ff, last_ff;
   logic [15:0] result_ff;
   tcc_byte_t   shadow_ff;
   tcc_addr_t   rd_addr_ff;
   tcc_byte_t   wr_data_ff;
   logic        wr_ff, rd_ff;
   logic        launch, is_cmd, c_we;
   tcc_addr_t   c_addr;
   tcc_byte_t   c_data;

   // ======================================
   // command decode; wstrb ignored, whole word taken
   assign launch = ~awready & ~wready & ~bvalid & (st_ff == H_IDLE);
   assign is_cmd = awaddr_ff == `TCC_X_CMD;
   assign c_we   = wdata_ff[`TCC_C_WE];
   assign c_addr = wdata_ff[12:8];
   assign c_data = wdata_ff[7:0];

   // ======================================
   // AXI write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `TCC_OKAY;
         awaddr_ff <= '0;
         wdata_ff  <= '0;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            awaddr_ff <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            wdata_ff <= wdata;
            wready   <= 1'b0;
         end
         if (launch) begin
            bvalid  <= 1'b1;
            bresp   <= is_cmd ? `TCC_OKAY : `TCC_SLVERR;
            awready <= 1'b1;
            wready  <= 1'b1;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ======================================
   // AXI read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `TCC_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `TCC_OKAY;
            unique case (araddr)
               `TCC_X_CMD:  rdata <= cmd_ff;
               `TCC_X_STAT: rdata <= {15'h0000, st_ff != H_IDLE,
                                      result_ff};
               default: begin
                  rdata <= '0;
                  rresp <= `TCC_SLVERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ======================================
   // access sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff      <= H_IDLE;
         cmd_ff     <= '0;
         idx_ff     <= 1'b0;
         last_ff    <= 1'b0;
         result_ff  <= '0;
         // mirrors the core after reset: counter halted
         shadow_ff  <= tcc_byte_t'(1 << `TCC_B_HALT);
         op_addr_ff <= '{default: '0};
         op_data_ff <= '{default: '0};
         op_we_ff   <= '{default: 1'b0};
         wr_ff      <= 1'b0;
         rd_ff      <= 1'b0;
         rd_addr_ff <= '0;
         wr_data_ff <= '0;
      end else if (clk_en) begin
         unique case (st_ff)
            H_IDLE: if (launch && is_cmd) begin
               cmd_ff        <= wdata_ff;
               result_ff     <= '0;
               idx_ff        <= 1'b0;
               st_ff         <= H_ISSUE;
               op_addr_ff[1] <= c_addr;
               op_data_ff[1] <= c_data;
               op_we_ff[1]   <= c_we;
               if (c_we && c_addr == `TCC_A_PER_HI) begin
                  // clear counter first; flag bit 1 leaves flag alone
                  op_addr_ff[0] <= `TCC_A_CTRL;
                  op_data_ff[0] <= shadow_ff |
                     tcc_byte_t'((1 << `TCC_B_CLR) |
                                 (1 << `TCC_B_FLAG));
                  op_we_ff[0]   <= 1'b1;
                  last_ff       <= 1'b1;
               end else if (!c_we && c_addr == `TCC_A_CNT_HI) begin
                  // always pair with low read so buffer is released
                  op_addr_ff[0] <= `TCC_A_CNT_HI;
                  op_we_ff[0]   <= 1'b0;
                  op_addr_ff[1] <= `TCC_A_CNT_LO;
                  last_ff       <= 1'b1;
               end else begin
                  op_addr_ff[0] <= c_addr;
                  op_data_ff[0] <= c_data;
                  op_we_ff[0]   <= c_we;
                  last_ff       <= 1'b0;
               end
               if (c_we && c_addr == `TCC_A_CTRL) begin
                  shadow_ff <= c_data &
                     ~tcc_byte_t'(1 << `TCC_B_CLR);
               end
            end
            H_ISSUE: begin
               wr_ff      <= op_we_ff[idx_ff];
               rd_ff      <= ~op_we_ff[idx_ff];
               rd_addr_ff <= op_addr_ff[idx_ff];
               wr_data_ff <= op_data_ff[idx_ff];
               st_ff      <= H_WAIT;
            end
            H_WAIT: begin
               wr_ff <= 1'b0;
               rd_ff <= 1'b0;
               if (op_we_ff[idx_ff] || bus.reg_rvalid) begin
                  if (!op_we_ff[idx_ff]) begin
                     result_ff <= {result_ff[7:0], bus.reg_rdata};
                  end
                  if (idx_ff == last_ff) begin
                     st_ff <= H_IDLE;
                  end else begin
                     idx_ff <= 1'b1;
                     st_ff  <= H_ISSUE;
                  end
               end
            end
         endcase
      end
   end
   assign bus.reg_wr    = wr_ff;
   assign bus.reg_rd    = rd_ff;
   assign bus.reg_addr  = rd_addr_ff;
   assign bus.reg_wdata = wr_data_ff;

   // ======================================
   // wait is only safe while the counter runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_allowed <= 1'b0;
      end else if (clk_en) begin
         wait_allowed <= ~shadow_ff[`TCC_B_HALT];
      end
   end
endmodule

// *** tcc_link_properties.sv ***
/*
 Checker for the byte link between host controller and timer core.
 Assumes one aclk, synchronous active-low reset and clk_en held high.
*/
`include "tcc_defines.svh"
module tcc_link_properties (
   // clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   // link signals
   input wire tcc_pkg::tcc_addr_t reg_addr,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire tcc_pkg::tcc_byte_t reg_wdata,
   input wire tcc_pkg::tcc_byte_t reg_rdata,
   input wire logic               reg_rvalid
);
   import tcc_pkg::*;
   logic clr_seen_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ======================================
   // remembers whether the last write asked for a counter clear
   always_ff @(posedge aclk) begin
      if (!aresetn) clr_seen_ff <= 1'b0;
      else if (reg_wr) clr_seen_ff <= (reg_addr == `TCC_A_CTRL) &&
                                      reg_wdata[`TCC_B_CLR];
   end
   // ======================================
   // link timing
   a_read_answer: assert property (
      reg_rd |=> reg_rvalid) else $error("read strobe not answered");
   a_no_stray: assert property (
      reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
   a_strobe_gap: assert property (
      (reg_rd || reg_wr) |=> !(reg_rd || reg_wr))
      else $error("strobes too close");
   a_one_strobe: assert property (
      !(reg_rd && reg_wr)) else $error("read and write together");
   a_rdata_hold: assert property (
      !reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
   // ======================================
   // register behaviour seen on the link
   a_pair_read: assert property (
      (reg_rd && reg_addr == `TCC_A_CNT_HI) |->
      ##[2:30] (reg_rd && reg_addr == `TCC_A_CNT_LO))
      else $error("high byte read not followed by low byte read");
   a_clear_first: assert property (
      (reg_wr && reg_addr == `TCC_A_PER_HI) |-> clr_seen_ff)
      else $error("period written without prior clear");
   a_ctrl_zero: assert property (
      (reg_rd && reg_addr == `TCC_A_CTRL) |=> reg_rdata[4:3] == 2'b00)
      else $error("clear bit read back nonzero");
endmodule

// *** tcc_tb.sv ***
/*
 Testbench: AXI4-Lite master driving host and core joined by tcc_if.
 Assumes the host's command/status map and one 100 MHz clock.
*/
`include "tcc_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid;
   logic        rready, awready, wready, bvalid, arready, rvalid;
   logic        wait_allowed, clock_pin_oe, capture_inhibit, wrap_irq;
   logic        wrap_event, external_timer_clock_pin, port_direction_bit;
   logic        break_active, ext_run;
   logic [3:0]  awaddr, araddr, wstrb, ext_div;
   logic [31:0] wdata, rdata, rd32;
   logic [1:0]  bresp, rresp, rsp, channel_mode, channel_pin_oe;
   logic [15:0] count_value, v;
   int          failures, checks, n;
   tcc_if tcc_if_inst ();
   tcc_core #(.PSC_W(6)) tcc_core_inst (.aclk, .aresetn, .clk_en,
      .bus(tcc_if_inst), .external_timer_clock_pin, .port_direction_bit,
      .break_active, .channel_mode, .clock_pin_oe, .channel_pin_oe,
      .capture_inhibit, .wrap_irq, .wrap_event, .count_value);
   tcc_host tcc_host_inst (.aclk, .aresetn, .clk_en, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .bus(tcc_if_inst), .wait_allowed);
   tcc_link_properties tcc_link_properties_inst (.aclk, .aresetn,
      .reg_addr(tcc_if_inst.reg_addr), .reg_wr(tcc_if_inst.reg_wr),
      .reg_rd(tcc_if_inst.reg_rd), .reg_wdata(tcc_if_inst.reg_wdata),
      .reg_rdata(tcc_if_inst.reg_rdata),
      .reg_rvalid(tcc_if_inst.reg_rvalid));
   // ======================================
   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = !aclk;
   end
   // external clock at bus/32, under both the 4 MHz and bus/2 ceilings
   always @(posedge aclk) begin
      if (ext_run) begin
         ext_div <= ext_div + 4'h1;
         if (ext_div == 4'hF) begin
            external_timer_clock_pin <= !external_timer_clock_pin;
         end
      end
   end
   // ======================================
   // reporting
   task automatic final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic guard(input int k);
      if (k >= 300) begin
         failures++;
         final_report();
      end
   endtask
   // ======================================
   // AXI4-Lite master cycles
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      int  k;
      logic aw, w;
      k = 0; aw = 0; w = 0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      while (!(aw && w) && k < 300) begin
         @(posedge aclk); k++;
         if (awvalid && awready) begin aw = 1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w = 1; wvalid <= 1'b0; end
      end
      bready <= 1'b1;
      do begin @(posedge aclk); k++; end while (bvalid !== 1'b1 && k < 300);
      rsp = bresp; bready <= 1'b0;
      guard(k);
   endtask
   task automatic axr(input logic [3:0] a);
      int k;
      k = 0;
      araddr <= a; arvalid <= 1'b1;
      do begin @(posedge aclk); k++; end while (arready !== 1'b1 && k < 300);
      arvalid <= 1'b0; rready <= 1'b1;
      while (rvalid !== 1'b1 && k < 300) begin @(posedge aclk); k++; end
      if (k == 1) @(posedge aclk); // rvalid comes a cycle after the take
      rd32 = rdata; rsp = rresp; rready <= 1'b0;
      guard(k);
   endtask
   // one command word to the host (one or two core accesses), then wait for idle
   task automatic cmd(input logic we, input logic [4:0] a, input logic [7:0] d);
      int k;
      k = 0;
      axw(`TCC_X_CMD, {15'h0, we, 3'h0, a, d});
      do begin axr(`TCC_X_STAT); k++; end while (rd32[16] !== 1'b0 && k < 300);
      v = rd32[15:0];
      guard(k);
   endtask
   task automatic ticks(input logic ev);
      int k;
      logic [15:0] c;
      k = 0;
      c = count_value;
      while ((ev ? !wrap_event : count_value === c) && k < 300) begin
         @(posedge aclk); k++;
      end
      c = count_value; n = 0;
      do begin @(posedge aclk); n++; end
      while ((ev ? !wrap_event : count_value === c) && n < 300);
      guard(k); guard(n);
   endtask
   // ======================================
   // scenarios
   task automatic t_reset;
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h0020);
      cmd(0, `TCC_A_PER_HI, 8'h00); chk(v, 16'h00FF);
      cmd(0, `TCC_A_PER_LO, 8'h00); chk(v, 16'h00FF);
      cmd(0, `TCC_A_CNT_HI, 8'h00); chk(v, 16'h0000);
      axr(4'h8); chk({14'h0, rsp}, {14'h0, `TCC_SLVERR});
      axw(4'h4, 32'h0); chk({14'h0, rsp}, {14'h0, `TCC_SLVERR});
      chk({15'h0, wait_allowed}, 16'h0000);
      chk({15'h0, capture_inhibit}, 16'h0001);
      chk({14'h0, channel_pin_oe}, 16'h0001);
      $display("reset test done");
   endtask
   task automatic t_wrap;
      cmd(1, `TCC_A_CTRL, 8'h30);
      cmd(1, `TCC_A_PER_HI, 8'h00);
      cmd(1, `TCC_A_PER_LO, 8'h10);
      cmd(1, `TCC_A_CTRL, 8'h40);
      ticks(1); chk(n[15:0], 16'h0011);
      chk({15'h0, wrap_irq}, 16'h0001);
      chk({15'h0, capture_inhibit}, 16'h0000);
      cmd(1, `TCC_A_CTRL, 8'h60);
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h00E0);
      cmd(1, `TCC_A_CTRL, 8'h60);
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h0060);
      chk({15'h0, wrap_irq}, 16'h0000);
      cmd(1, `TCC_A_CTRL, 8'h30);
      repeat (10) @(posedge aclk);
      chk(count_value, 16'h0000);
      cmd(0, `TCC_A_CNT_HI, 8'h00); chk(v, 16'h0000);
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h0020);
      $display("wrap test done");
   endtask
   task automatic t_hold;
      // period high write alone: wraps go on but raise no flag
      cmd(1, `TCC_A_PER_HI, 8'h00);
      cmd(1, `TCC_A_CTRL, 8'h00);
      repeat (60) @(posedge aclk);
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h0000);
      cmd(1, `TCC_A_PER_LO, 8'h10);
      repeat (60) @(posedge aclk);
      cmd(0, `TCC_A_CTRL, 8'h00); chk(v, 16'h0080);
      cmd(1, `TCC_A_CTRL, 8'h30);
      $display("period hold test done");
   endtask
   task automatic t_presc;
      cmd(1, `TCC_A_PER_HI, 8'hFF);
      cmd(1, `TCC_A_PER_LO, 8'hFF);
      for (int s = 0; s < 7; s++) begin
         cmd(1, `TCC_A_CTRL, 8'h30);
         cmd(1, `TCC_A_CTRL, 8'(s));
         ticks(0); chk(n[15:0], 16'(1 << s));
      end
      port_direction_bit <= 1'b1;
      ext_run <= 1'b1;
      cmd(1, `TCC_A_CTRL, 8'h07);
      chk({15'h0, clock_pin_oe}, 16'h0000);
      chk({15'h0, wait_allowed}, 16'h0001);
      ticks(0); chk(n[15:0], 16'h0020);
      cmd(1, `TCC_A_CTRL, 8'h20);
      chk({15'h0, clock_pin_oe}, 16'h0001);
      $display("prescaler test done");
   endtask
   // ======================================
   // main sequence
   initial begin
      failures = 0; checks = 0; n = 0;
      aresetn = 1'b0; clk_en = 1'b1; break_active = 1'b0; wstrb = 4'hF;
      awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; ext_run = 1'b0;
      ext_div = 4'h0; external_timer_clock_pin = 1'b0;
      port_direction_bit = 1'b0; channel_mode = 2'b01;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_wrap();
      t_hold();
      t_presc();
      final_report();
   end
endmodule
